/* File: include/sysclk_cfg.svh */
// Purpose: constants of the system clock and power mode block
// Assumes: pclk at 20 MHz drives every flip-flop
// Notes: included by its bare name
`ifndef SYSCLK_CFG_SVH
`define SYSCLK_CFG_SVH

// ----------------------------------------
// clock rates
// ----------------------------------------
`define SYS_PCLK_HZ 20000000
`define SYS_FAST_HZ 8000000
`define SYS_SLOW_HZ 32000
`define SYS_FAST_STABLE_CYCLES 16

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CLOCK_MODE_CONTROL 12'h000
`define OFS_POWER_AUX_FLAGS 12'h004
`define OFS_POWER_STATUS 12'h008

// ----------------------------------------
// clock_mode_control fields
// ----------------------------------------
`define CMC_DIV_MSB 7
`define CMC_DIV_LSB 5
`define CMC_SLOW_RDY 3
`define CMC_FAST_RDY 2
`define CMC_IDLE_SEL 1
`define CMC_HIGH_CLK 0
`define CMC_DIV_RESET 3'h0
`define CMC_IDLE_SEL_RESET 1'b1
`define CMC_HIGH_CLK_RESET 1'b1
`define DIV_FIRST_FAST 3'h2
`define DIV_SHIFT_BASE 4'h8

// ----------------------------------------
// power_aux_flags and status fields
// ----------------------------------------
`define PAF_KEEP 7
`define PAF_D3 3
`define PAF_LOW_VOLTAGE_RESET_FLAG 2
`define PAF_WRF 0
`define STS_PDF 0
`define STS_TO 1

// ----------------------------------------
// fast divider taps and slow ready tick count
// ----------------------------------------
`define FAST_TAP16 6'h0F
`define FAST_TAP64 6'h3F
`define SLOW_READY_TICKS 2'h2

`endif

/* File: include/sysclk_pkg.sv */
// Purpose: types of the system clock and power mode block
// Assumes: nothing
// Notes: constants live in sysclk_cfg.svh
package sysclk_pkg;
	typedef enum logic [2:0] {
		MODE_RUN = 3'b000,
		MODE_IDLE0 = 3'b001,
		MODE_IDLE1 = 3'b010,
		MODE_SLEEP0 = 3'b011,
		MODE_SLEEP1 = 3'b100
	} power_mode_t;
endpackage

/* File: include/osc_tick_if.sv */
// Purpose: enable and tick pair between a tick generator and its user
// Assumes: both ends on pclk
// Notes: tick is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
interface osc_tick_if;
	logic run;
	logic tick;
	modport src (input run, output tick);
	modport sink (output run, input tick);
endinterface
`default_nettype wire

/* File: src/osc_tick_gen.sv */
// Purpose: models an oscillator as a tick enable divided from pclk
// Assumes: RATIO of at least 1
// Notes: counter restarts while stopped, so the first tick is a full period
`timescale 1ns/100ps
`default_nettype none
module osc_tick_gen #(
	parameter int RATIO = 2
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// tick pair
	osc_tick_if.src t
);
	localparam int CW = (RATIO > 1) ? $clog2(RATIO) : 1;
	localparam logic [CW-1:0] LAST = CW'(RATIO - 1);
	logic [CW-1:0] cnt_q;
	logic tick_q;
	wire at_last = (cnt_q == LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (!t.run) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= at_last ? '0 : cnt_q + CW'(1);
			tick_q <= at_last;
		end
	end

	assign t.tick = tick_q;
endmodule
`default_nettype wire

/* File: src/sysclk_power_mode_control.sv */
// Purpose: system clock selection and halt power modes behind an APB slave
// Assumes: clocks are modelled as one-cycle enables on pclk
// Notes:
// Function
// R1: divider field selects slow or fast divided
// R2: high clock bit selects undivided fast clock
// R3: fast oscillator stops when slow clock selected
// R4: fast peripheral taps stop with fast oscillator
// R5: slow ready low in deep sleep, rises
// R6: fast ready cleared at reset, set stable
// R7: halt with idle select enters idle mode
// R8: halt otherwise sleeps, depth from watchdog
// R9: deep sleep stops all clocks, holds watchdog
// R10: light sleep keeps watchdog on slow clock
// R11: idle0 stops system clock, keeps time base
// R12: idle1 keeps system and time base clocks
// R13: light sleep and idle clear watchdog counter
// R14: any halt sets power-down, clears expiry
// R15: halt modes keep register contents unchanged
// R16: low voltage flag cleared only by software
// R17: watchdog control reset flag set by hardware
// R18: software selects slow, waits slow ready
// R19: software selects fast, checks fast ready
// R20: unimplemented bits read zero, ignore writes
// R21: fast clock 8MHz, slow clock 32kHz; the model divides pclk by 2 for the fast clock, giving 10MHz at 20 MHz pclk
// R22: clock source switches without runt pulses
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "sysclk_cfg.svh"
module sysclk_power_mode_control
	import sysclk_pkg::*;
#(
	parameter int FAST_STABLE_CYCLES = `SYS_FAST_STABLE_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core and watchdog events
	input wire logic halt_req,
	input wire logic wake_req,
	input wire logic wdt_enabled,
	input wire logic wdt_timeout,
	input wire logic clear_wdt_req,
	input wire logic lvr_event,
	input wire logic wdog_ctrl_reset_event,
	// clock enables
	output logic sysclk_tick,
	output logic tbc_tick,
	output logic wdt_tick,
	output logic fast_div16_tick,
	output logic fast_div64_tick,
	// power state
	output logic fast_osc_enable,
	output logic slow_osc_enable,
	output logic cpu_run,
	output logic wdt_counter_clear,
	output logic wdt_counter_hold,
	output logic [2:0] power_mode,
	output logic power_down_flag,
	output logic watchdog_expiry_flag
);
	// ----------------------------------------
	// oscillator models
	// ----------------------------------------
	localparam int FAST_RATIO = `SYS_PCLK_HZ / `SYS_FAST_HZ; // R21
	localparam int SLOW_RATIO = `SYS_PCLK_HZ / `SYS_SLOW_HZ; // R21
	localparam int FSW = $clog2(FAST_STABLE_CYCLES + 1);
	localparam logic [FSW-1:0] FAST_STABLE = FSW'(FAST_STABLE_CYCLES);

	osc_tick_if fast_if();
	osc_tick_if slow_if();

	osc_tick_gen #(.RATIO(FAST_RATIO)) u_fast_osc (
		.pclk(pclk),
		.presetn(presetn),
		.t(fast_if)
	);
	osc_tick_gen #(.RATIO(SLOW_RATIO)) u_slow_osc (
		.pclk(pclk),
		.presetn(presetn),
		.t(slow_if)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	power_mode_t mode_q, mode_d;
	logic [2:0] div_sel_q;
	logic idle_sel_q, high_clk_q;
	logic keep_q, rsvd_d3_q, low_voltage_reset_flag_q, wrf_q;
	logic pdf_q, to_q;
	logic fast_on_q, slow_on_q;
	logic fast_rdy_q, slow_rdy_q;
	logic [FSW-1:0] fast_cnt_q;
	logic [1:0] slow_cnt_q;
	logic [5:0] fdiv_q;
	logic act_fast_q;
	logic [2:0] act_k_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic sys_tick_q, tbc_q, wdt_q, d16_q, d64_q;
	logic wclr_q, whold_q, run_q;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire setup = psel & ~penable;
	wire access = psel & penable & pready_q;
	wire hit_cmc = (paddr == `OFS_CLOCK_MODE_CONTROL);
	wire hit_paf = (paddr == `OFS_POWER_AUX_FLAGS);
	wire hit_sts = (paddr == `OFS_POWER_STATUS);
	wire mapped = hit_cmc | hit_paf | hit_sts;
	// writes land only with the low byte lane enabled; status is read only
	wire wr_ok = access & pwrite & pstrb[0] & ~pslverr_q;
	wire wr_cmc = wr_ok & hit_cmc;
	wire wr_paf = wr_ok & hit_paf;

	// unused positions stay zero on read
	wire [7:0] cmc_rd = {div_sel_q, 1'b0, slow_rdy_q, fast_rdy_q, idle_sel_q, high_clk_q}; // R20
	wire [7:0] paf_rd = {keep_q, 3'h0, rsvd_d3_q, low_voltage_reset_flag_q, 1'b0, wrf_q}; // R20
	wire [7:0] sts_rd = {6'h00, to_q, pdf_q};
	wire [7:0] rd_byte = hit_cmc ? cmc_rd : hit_paf ? paf_rd : hit_sts ? sts_rd : 8'h00;

	// ----------------------------------------
	// requested clock source
	// ----------------------------------------
	wire div_fast = (div_sel_q >= `DIV_FIRST_FAST); // R1
	wire req_fast = high_clk_q | div_fast; // R2
	// 010 gives shift 6 (/64), 111 gives shift 1 (/2)
	wire [2:0] div_k = 3'(`DIV_SHIFT_BASE - {1'b0, div_sel_q}); // R1
	wire [2:0] req_k = high_clk_q ? 3'h0 : div_k; // R2
	wire [6:0] act_mask_w = (7'h01 << act_k_q) - 7'h01;
	wire [5:0] act_mask = act_mask_w[5:0];
	wire fast_ok = fast_on_q & fast_rdy_q;
	wire fast_tick = fast_if.tick & fast_ok;
	wire slow_tick = slow_if.tick & slow_on_q;
	wire fast_src_tick = fast_tick & ((fdiv_q & act_mask) == act_mask);
	wire src_tick = act_fast_q ? fast_src_tick : slow_tick;
	// switch only on a tick of the old source: its period is complete,
	// and the new source must already be ready, so no runt pulse appears
	wire tgt_ready = req_fast ? fast_ok : slow_rdy_q; // R18 R19
	wire sel_differs = (req_fast != act_fast_q) | (req_fast & (req_k != act_k_q));
	// a fast-to-fast change waits for the divider wrap so both taps align
	wire fast_wrap = fast_tick & (fdiv_q == `FAST_TAP64);
	wire boundary = act_fast_q ? (req_fast ? fast_wrap : fast_src_tick) : slow_tick;
	wire do_switch = sel_differs & tgt_ready & boundary; // R22

	// ----------------------------------------
	// halt mode decision
	// ----------------------------------------
	wire in_run = (mode_q == MODE_RUN);
	wire enter_halt = in_run & halt_req;
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			MODE_RUN: begin
				if (halt_req) begin
					if (idle_sel_q) begin
						mode_d = keep_q ? MODE_IDLE1 : MODE_IDLE0; // R7
					end else begin
						mode_d = wdt_enabled ? MODE_SLEEP1 : MODE_SLEEP0; // R8
					end
				end
			end
			MODE_IDLE0, MODE_IDLE1, MODE_SLEEP0, MODE_SLEEP1: begin
				if (wake_req) begin
					mode_d = MODE_RUN;
				end
			end
			default: begin
				mode_d = MODE_RUN;
			end
		endcase
	end

	wire sysclk_live = in_run | (mode_q == MODE_IDLE1); // R11 R12
	wire tbc_live = in_run | (mode_q == MODE_IDLE0) | (mode_q == MODE_IDLE1); // R9 R10 R11 R12
	wire wdt_live = (mode_q != MODE_SLEEP0); // R9 R10
	wire fast_want = (act_fast_q | req_fast) & sysclk_live; // R3
	wire slow_want = (mode_q != MODE_SLEEP0); // R5 R9
	wire halt_to_sleep0 = enter_halt & ~idle_sel_q & ~wdt_enabled;

	assign fast_if.run = fast_on_q;
	assign slow_if.run = slow_on_q;

	// ----------------------------------------
	// apb response
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			if (setup) begin
				prdata_q <= {24'h00_0000, rd_byte};
			end
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// halt modes touch none of these, so contents survive sleep and idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_sel_q <= `CMC_DIV_RESET;
			idle_sel_q <= `CMC_IDLE_SEL_RESET;
			high_clk_q <= `CMC_HIGH_CLK_RESET;
			keep_q <= 1'b0;
			rsvd_d3_q <= 1'b0;
		end else begin
			if (wr_cmc) begin // R15
				div_sel_q <= pwdata[`CMC_DIV_MSB:`CMC_DIV_LSB];
				idle_sel_q <= pwdata[`CMC_IDLE_SEL];
				high_clk_q <= pwdata[`CMC_HIGH_CLK];
			end
			if (wr_paf) begin
				keep_q <= pwdata[`PAF_KEEP];
				rsvd_d3_q <= pwdata[`PAF_D3];
			end
		end
	end

	// ----------------------------------------
	// reset source flags
	// ----------------------------------------
	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_voltage_reset_flag_q <= 1'b0;
			wrf_q <= 1'b0;
		end else begin
			low_voltage_reset_flag_q <= lvr_event | (low_voltage_reset_flag_q & ~(wr_paf & ~pwdata[`PAF_LOW_VOLTAGE_RESET_FLAG])); // R16
			wrf_q <= wdog_ctrl_reset_event | (wrf_q & ~(wr_paf & ~pwdata[`PAF_WRF])); // R17
		end
	end

	// ----------------------------------------
	// power mode and status flags
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= MODE_RUN;
			pdf_q <= 1'b0;
			to_q <= 1'b0;
			wclr_q <= 1'b0;
			whold_q <= 1'b0;
			run_q <= 1'b1;
		end else begin
			mode_q <= mode_d;
			run_q <= (mode_d == MODE_RUN); // R7 R8
			pdf_q <= enter_halt | (pdf_q & ~clear_wdt_req); // R14
			to_q <= wdt_timeout | (to_q & ~enter_halt); // R14
			wclr_q <= enter_halt; // R9 R13
			if (halt_to_sleep0) begin
				whold_q <= 1'b1; // R9
			end else if (mode_d != MODE_SLEEP0) begin
				whold_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// oscillator control and ready flags
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_on_q <= 1'b1;
			slow_on_q <= 1'b1;
			fast_rdy_q <= 1'b0;
			fast_cnt_q <= '0;
			slow_rdy_q <= 1'b0;
			slow_cnt_q <= 2'h0;
		end else begin
			fast_on_q <= fast_want; // R3
			slow_on_q <= slow_want;
			if (!fast_on_q) begin
				fast_rdy_q <= 1'b0;
				fast_cnt_q <= '0;
			end else if (!fast_rdy_q) begin
				fast_cnt_q <= fast_cnt_q + FSW'(1);
				fast_rdy_q <= (fast_cnt_q == FAST_STABLE - FSW'(1)); // R6
			end
			if (!slow_on_q) begin
				slow_rdy_q <= 1'b0; // R5
				slow_cnt_q <= 2'h0;
			end else if (!slow_rdy_q && slow_if.tick) begin
				slow_cnt_q <= slow_cnt_q + 2'h1;
				slow_rdy_q <= (slow_cnt_q == `SLOW_READY_TICKS - 2'h1); // R5
			end
		end
	end

	// ----------------------------------------
	// source selection and fast divider
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_fast_q <= 1'b1;
			act_k_q <= 3'h0;
			fdiv_q <= 6'h00;
		end else begin
			if (!fast_on_q) begin
				fdiv_q <= 6'h00;
			end else if (fast_tick) begin
				fdiv_q <= fdiv_q + 6'h01;
			end
			if (do_switch) begin // R22
				act_fast_q <= req_fast; // R1 R2
				act_k_q <= req_k;
			end
		end
	end

	// ----------------------------------------
	// clock enables
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_tick_q <= 1'b0;
			tbc_q <= 1'b0;
			wdt_q <= 1'b0;
			d16_q <= 1'b0;
			d64_q <= 1'b0;
		end else begin
			sys_tick_q <= src_tick & sysclk_live; // R7 R11 R12
			tbc_q <= slow_tick & tbc_live; // R11 R12
			wdt_q <= slow_tick & wdt_live; // R10
			// both taps vanish whenever the fast oscillator is off
			d16_q <= fast_tick & ((fdiv_q & `FAST_TAP16) == `FAST_TAP16); // R4
			d64_q <= fast_tick & (fdiv_q == `FAST_TAP64); // R4
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign sysclk_tick = sys_tick_q;
	assign tbc_tick = tbc_q;
	assign wdt_tick = wdt_q;
	assign fast_div16_tick = d16_q;
	assign fast_div64_tick = d64_q;
	assign fast_osc_enable = fast_on_q;
	assign slow_osc_enable = slow_on_q;
	assign cpu_run = run_q;
	assign wdt_counter_clear = wclr_q;
	assign wdt_counter_hold = whold_q;
	assign power_mode = mode_q;
	assign power_down_flag = pdf_q;
	assign watchdog_expiry_flag = to_q;
endmodule
`default_nettype wire

/* File: test/sysclk_monitor.sv */
// Purpose: port checker for the clock and power mode block
// Assumes: one pclk domain
// Notes: bound to every instance
`timescale 1ns/100ps
`default_nettype none
module sysclk_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// events and state
	input wire logic halt_req,
	input wire logic wdt_timeout,
	input wire logic cpu_run,
	input wire logic [2:0] power_mode,
	input wire logic wdt_counter_clear,
	input wire logic wdt_counter_hold,
	input wire logic power_down_flag,
	input wire logic watchdog_expiry_flag,
	input wire logic slow_osc_enable,
	input wire logic fast_osc_enable,
	// ticks
	input wire logic sysclk_tick,
	input wire logic tbc_tick,
	input wire logic wdt_tick,
	input wire logic fast_div16_tick,
	input wire logic fast_div64_tick
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// --------
	// halt entry
	// --------
	AST_HALT_ENTRY: assert property (halt_req && cpu_run && !wdt_timeout |=>
		!cpu_run && power_mode != 3'b000 && power_down_flag && !watchdog_expiry_flag &&
		wdt_counter_clear) else $error("bad halt entry");
	AST_CLEAR_PULSE: assert property (wdt_counter_clear |-> $past(halt_req) && $past(cpu_run) ##1 !wdt_counter_clear)
		else $error("bad watchdog clear");
	// --------
	// gating per mode
	// --------
	// ticks may still fire in the entry cycle, so look one cycle in
	AST_DEEP_HOLD: assert property (power_mode == 3'b011 |-> wdt_counter_hold) else $error("no hold");
	AST_DEEP_STOP: assert property (power_mode == 3'b011 && $past(power_mode) == 3'b011 |->
		!sysclk_tick && !tbc_tick && !wdt_tick && !slow_osc_enable) else $error("deep sleep clocks run");
	AST_LIGHT_STOP: assert property (power_mode == 3'b100 && $past(power_mode) == 3'b100 |->
		!sysclk_tick && !tbc_tick && !wdt_counter_hold) else $error("light sleep clocks run");
	AST_IDLE0_STOP: assert property (power_mode == 3'b001 && $past(power_mode) == 3'b001 |-> !sysclk_tick)
		else $error("idle0 system clock runs");
	AST_IDLE1_RUN: assert property (power_mode == 3'b010 && $past(power_mode) != 3'b010 |->
		##[1:700] (tbc_tick || power_mode != 3'b010)) else $error("idle1 time base stopped");
	AST_FAST_TAPS: assert property (!fast_osc_enable && !$past(fast_osc_enable) |->
		!fast_div16_tick && !fast_div64_tick) else $error("fast taps run with oscillator off");
endmodule
bind sysclk_power_mode_control sysclk_monitor i_mon (.pclk, .presetn, .halt_req, .wdt_timeout, .cpu_run,
	.power_mode, .wdt_counter_clear, .wdt_counter_hold, .power_down_flag, .watchdog_expiry_flag,
	.slow_osc_enable, .fast_osc_enable, .sysclk_tick, .tbc_tick, .wdt_tick, .fast_div16_tick, .fast_div64_tick);
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: directed bench for the clock and power mode block
// Assumes: zero wait apb, fast tick every 2 pclk, slow every 625
// Notes: offsets 0x000, 0x004, 0x008
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, e;
	logic halt_req = 1'b0, wake_req = 1'b0, wdt_enabled = 1'b0, wdt_timeout = 1'b0;
	logic clear_wdt_req = 1'b0, lvr_event = 1'b0, wdog_ctrl_reset_event = 1'b0;
	logic sysclk_tick, tbc_tick, wdt_tick, fast_div16_tick, fast_div64_tick;
	logic fast_osc_enable, slow_osc_enable, cpu_run, wdt_counter_clear, wdt_counter_hold;
	logic power_down_flag, watchdog_expiry_flag;
	logic [2:0] power_mode;
	logic [4:0] s;
	logic [2:0] mode_exp [4] = '{3'b011, 3'b100, 3'b001, 3'b010};
	logic [2:0] tick_exp [4] = '{3'b000, 3'b001, 3'b011, 3'b111};
	int failures = 0, cmp_count = 0, n, k, i;
	always #25 pclk = ~pclk;
	sysclk_power_mode_control #(.FAST_STABLE_CYCLES(16)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .halt_req, .wake_req, .wdt_enabled,
		.wdt_timeout, .clear_wdt_req, .lvr_event, .wdog_ctrl_reset_event, .sysclk_tick, .tbc_tick, .wdt_tick,
		.fast_div16_tick, .fast_div64_tick, .fast_osc_enable, .slow_osc_enable, .cpu_run,
		.wdt_counter_clear, .wdt_counter_hold, .power_mode, .power_down_flag, .watchdog_expiry_flag);
	// --------
	// tasks
	// --------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int t;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (pready !== 1'b1) begin
			failures++;
			close_out();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk(r, {24'h0, x});
	endtask
	// a switch may wait for a divider wrap or a slow tick, so settle first;
	// the first interval is partial, the second is measured
	task automatic period(input int exp);
		repeat (700) @(posedge pclk);
		for (k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (sysclk_tick !== 1'b1 && n < 2000);
		end
		chk(32'(n), 32'(exp));
		if (n >= 2000) begin
			failures++;
			close_out();
		end
	endtask
	task automatic seen();
		s = 5'h00;
		repeat (1400) begin
			@(posedge pclk);
			s = s | {fast_div64_tick, fast_div16_tick, sysclk_tick, tbc_tick, wdt_tick};
		end
	endtask
	task automatic close_out();
		$display("compares=%0d errors=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#3000000;
		failures++;
		close_out();
	end
	// --------
	// sequence
	// --------
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h000, 8'h03);
		repeat (1300) @(posedge pclk);
		rd(12'h000, 8'h0F);
		rd(12'h004, 8'h00);
		apb(1'b1, 12'h004, 8'hFF);
		rd(12'h004, 8'h88);
		apb(1'b1, 12'h000, 8'hFF);
		rd(12'h000, 8'hEF);
		apb(1'b1, 12'h008, 8'hFF);
		rd(12'h008, 8'h00);
		rd(12'h00C, 8'h00);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, 12'h004, 8'h00);
		lvr_event <= 1'b1;
		wdog_ctrl_reset_event <= 1'b1;
		@(posedge pclk);
		lvr_event <= 1'b0;
		wdog_ctrl_reset_event <= 1'b0;
		rd(12'h004, 8'h05);
		apb(1'b1, 12'h004, 8'h05);
		rd(12'h004, 8'h05);
		apb(1'b1, 12'h004, 8'h00);
		rd(12'h004, 8'h00);
		apb(1'b1, 12'h000, 8'h03);
		period(2);
		seen();
		chk({27'h0, s}, 32'h1F);
		for (i = 2; i < 8; i++) begin
			apb(1'b1, 12'h000, 8'(i << 5) | 8'h02);
			period(1 << (9 - i));
		end
		apb(1'b1, 12'h000, 8'h02);
		period(625);
		apb(1'b1, 12'h000, 8'h22);
		period(625);
		chk({31'h0, fast_osc_enable}, 32'h0);
		seen();
		chk({30'h0, s[4:3]}, 32'h0);
		apb(1'b1, 12'h000, 8'h03);
		period(2);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, 12'h000, {6'h0, i[1], 1'b1});
			apb(1'b1, 12'h004, {i[0], 7'h0});
			wdt_enabled <= i[0];
			wdt_timeout <= 1'b1;
			@(posedge pclk);
			wdt_timeout <= 1'b0;
			halt_req <= 1'b1;
			@(posedge pclk);
			halt_req <= 1'b0;
			#1;
			chk({29'h0, power_mode}, {29'h0, mode_exp[i]});
			chk({29'h0, cpu_run, power_down_flag, watchdog_expiry_flag}, 32'h2);
			@(posedge pclk);
			seen();
			chk({29'h0, s[2:0]}, {29'h0, tick_exp[i]});
			rd(12'h004, {i[0], 7'h0});
			rd(12'h008, 8'h01);
			wake_req <= 1'b1;
			@(posedge pclk);
			wake_req <= 1'b0;
			if (i == 0) rd(12'h000, 8'h01);
			clear_wdt_req <= 1'b1;
			@(posedge pclk);
			clear_wdt_req <= 1'b0;
			rd(12'h008, 8'h00);
			repeat (1300) @(posedge pclk);
			rd(12'h000, {6'h3, i[1], 1'b1});
		end
		close_out();
	end
endmodule
`default_nettype wire
